// file: gci_defs.svh
`ifndef GCI_DEFS_SVH
`define GCI_DEFS_SVH
// serial word layout, msb first
`define GCI_WORD_W 8
`define GCI_GAIN_W 5
`define GCI_RW_BIT 7
`define GCI_STEP_HI 6
`define GCI_STEP_LO 5
`define GCI_GAIN_MSB 4
`define GCI_LAST_BIT 3'h7
// gain code: 0 is maximum gain, 31 is minimum gain
`define GCI_GAIN_MIN_CODE 5'h1F
`define GCI_GAIN_RST 5'h1F
`define GCI_STEP_RST 2'h0
// idle pin levels: parallel, latched, chip select high, serial clock low
`define GCI_PIN_RST 10'h308
// fast-attack steps in gain codes of 1 dB each
`define GCI_STEP_1DB 5'h01
`define GCI_STEP_2DB 5'h02
`define GCI_STEP_4DB 5'h04
`define GCI_STEP_8DB 5'h08
`endif

// file: gci_gain_control.sv
`include "gci_defs.svh"

// Contract
// - mode pin low serial, high parallel
// - bit4 pin doubles as serial clock
// - bit3 pin doubles as chip select
// - bit2 pin doubles as fast attack
// - bits 1 and 0 parallel only
// - data pin bidirectional in serial mode
// - latch low transparent, high latched
// - power-up pin high powers device
// - perf pin low high performance
// - sample serial data on rising clock
// - drive read bit after falling clock
// - release data pin after chip select
// - eight bits: rw, step, gain, msb first
// - read flag shifts next eight out
// - fast attack lowers gain by step
// - transparent follows bits, latched holds
module gci_gain_control (
  input wire logic clock, // 10 MHz system clock
  input wire logic resetn, // async reset, active low
  input wire logic clockEnable, // freezes all state while low
  input wire logic modeSel, // high parallel, low serial
  input wire logic gain_bit4_or_sclk, // gain bit 4 or serial clock
  input wire logic gain_bit3_or_csn, // gain bit 3 or chip select
  input wire logic gain_bit2_or_fast_attack, // gain bit 2 or fast attack
  input wire logic gain_bit1, // gain bit 1
  input wire logic gain_bit0, // gain bit 0
  input wire logic latchSel, // high holds parallel gain
  input wire logic power_up_ctrl, // high powers up
  input wire logic perf_mode_sel, // high selects low power
  input wire logic sdioIn, // serial data pin level
  output logic sdioOut, // serial data driven level
  output logic sdioOe, // high while driving data pin
  output logic [`GCI_GAIN_W-1:0] gainCode, // applied gain code
  output logic serialMode, // serial interface active
  output logic poweredUp, // device powered
  output logic lowPowerMode, // low power operation
  output logic fastAttackActive // fast attack reduction applied
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  function automatic logic [`GCI_GAIN_W-1:0] stepOf(input logic [1:0] sel);
    case (sel)
      2'h0: stepOf = `GCI_STEP_1DB;
      2'h1: stepOf = `GCI_STEP_2DB;
      2'h2: stepOf = `GCI_STEP_4DB;
      default: stepOf = `GCI_STEP_8DB;
    endcase
  endfunction

  gci_pkg::gci_pins_t pinRaw;
  gci_pkg::gci_pins_t pinMeta_q;
  gci_pkg::gci_pins_t pinSync_q;
  gci_pkg::gci_pins_t pinPrev_q;

  always_comb begin
    pinRaw.mode = modeSel;
    pinRaw.latch = latchSel;
    pinRaw.pwr = power_up_ctrl;
    pinRaw.perf = perf_mode_sel;
    pinRaw.sdio = sdioIn;
    pinRaw.b4 = gain_bit4_or_sclk;
    pinRaw.b3 = gain_bit3_or_csn;
    pinRaw.b2 = gain_bit2_or_fast_attack;
    pinRaw.b1 = gain_bit1;
    pinRaw.b0 = gain_bit0;
  end

  // meta stage is read only by the sync stage
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      // idle levels, so reset shows no false clock edge or serial glitch
      pinMeta_q <= gci_pkg::gci_pins_t'(`GCI_PIN_RST);
      pinSync_q <= gci_pkg::gci_pins_t'(`GCI_PIN_RST);
      pinPrev_q <= gci_pkg::gci_pins_t'(`GCI_PIN_RST);
    end else if (clockEnable) begin
      pinMeta_q <= pinRaw;
      pinSync_q <= pinMeta_q;
      pinPrev_q <= pinSync_q;
    end
  end

  logic serSel;
  logic csActive;
  logic sclkRise;
  logic sclkFall;
  logic [`GCI_GAIN_W-1:0] parPins;

  always_comb begin
    serSel = !pinSync_q.mode;
    csActive = serSel && !pinSync_q.b3;
    sclkRise = serSel && pinSync_q.b4 && !pinPrev_q.b4;
    sclkFall = serSel && !pinSync_q.b4 && pinPrev_q.b4;
    parPins = {pinSync_q.b4, pinSync_q.b3, pinSync_q.b2,
      pinSync_q.b1, pinSync_q.b0};
  end

  ////////////////////////////////////////////////////////////////////////
  // serial shifter and gain selection

  gci_pkg::gci_state_t state_q, state_d;
  logic [2:0] bitCnt_q, bitCnt_d;
  logic [`GCI_WORD_W-1:0] shiftIn_q, shiftIn_d;
  logic [`GCI_WORD_W-1:0] readShift_q, readShift_d;
  logic [1:0] stepSel_q, stepSel_d;
  logic [`GCI_GAIN_W-1:0] regGain_q, regGain_d;
  logic [`GCI_GAIN_W-1:0] parGain_q, parGain_d;
  logic [`GCI_GAIN_W-1:0] gain_q, gain_d;
  logic sdioOut_q, sdioOut_d;
  logic sdioOe_q, sdioOe_d;
  logic serial_q, serial_d;
  logic power_q, power_d;
  logic lowPwr_q, lowPwr_d;
  logic fa_q, fa_d;
  logic [`GCI_WORD_W-1:0] wordIn;
  logic [`GCI_GAIN_W:0] faSum;

  always_comb begin
    state_d = state_q;
    bitCnt_d = bitCnt_q;
    shiftIn_d = shiftIn_q;
    readShift_d = readShift_q;
    stepSel_d = stepSel_q;
    regGain_d = regGain_q;
    sdioOut_d = sdioOut_q;
    sdioOe_d = sdioOe_q;
    wordIn = {shiftIn_q[`GCI_WORD_W-2:0], pinSync_q.sdio};
    if (!serSel) begin
      state_d = gci_pkg::GCI_SER_WRITE;
      bitCnt_d = 3'h0;
      sdioOe_d = 1'b0;
    end else if (!csActive) begin
      // a frame ends here; a read must finish in the frame that asked
      bitCnt_d = 3'h0;
      sdioOe_d = 1'b0;
      state_d = gci_pkg::GCI_SER_WRITE;
    end else begin
      case (state_q)
        gci_pkg::GCI_SER_WRITE: begin
          if (sclkRise) begin
            shiftIn_d = wordIn;
            bitCnt_d = bitCnt_q + 3'h1;
            if (bitCnt_q == `GCI_LAST_BIT) begin
              if (wordIn[`GCI_RW_BIT]) begin
                state_d = gci_pkg::GCI_SER_READ;
                readShift_d = {1'b0, stepSel_q, regGain_q};
              end else begin
                stepSel_d = wordIn[`GCI_STEP_HI:`GCI_STEP_LO];
                regGain_d = wordIn[`GCI_GAIN_MSB:0];
              end
            end
          end
        end
        gci_pkg::GCI_SER_READ: begin
          if (sclkFall) begin
            sdioOe_d = 1'b1;
            sdioOut_d = readShift_q[`GCI_WORD_W-1];
            readShift_d = {readShift_q[`GCI_WORD_W-2:0], 1'b0};
          end
          if (sclkRise) begin
            bitCnt_d = bitCnt_q + 3'h1;
            if (bitCnt_q == `GCI_LAST_BIT) begin
              state_d = gci_pkg::GCI_SER_WRITE;
              sdioOe_d = 1'b0;
            end
          end
        end
        default: begin
          state_d = gci_pkg::GCI_SER_WRITE;
          bitCnt_d = 3'h0;
          sdioOe_d = 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    parGain_d = parGain_q;
    if (!serSel && !pinSync_q.latch) begin
      parGain_d = parPins;
    end
    // code 0 is max gain, so a reduction adds to the code
    faSum = {1'b0, regGain_q} + {1'b0, stepOf(stepSel_q)};
    fa_d = serSel && pinSync_q.b2;
    if (!serSel) begin
      gain_d = parGain_d;
    end else if (fa_d) begin
      gain_d = faSum[`GCI_GAIN_W] ? `GCI_GAIN_MIN_CODE
        : faSum[`GCI_GAIN_W-1:0];
    end else begin
      gain_d = regGain_q;
    end
    serial_d = serSel;
    power_d = pinSync_q.pwr;
    lowPwr_d = pinSync_q.perf;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q <= gci_pkg::GCI_SER_WRITE;
      bitCnt_q <= 3'h0;
      shiftIn_q <= 8'h00;
      readShift_q <= 8'h00;
      stepSel_q <= `GCI_STEP_RST;
      regGain_q <= `GCI_GAIN_RST;
      parGain_q <= `GCI_GAIN_RST;
      gain_q <= `GCI_GAIN_RST;
      sdioOut_q <= 1'b0;
      sdioOe_q <= 1'b0;
      serial_q <= 1'b0;
      power_q <= 1'b0;
      lowPwr_q <= 1'b0;
      fa_q <= 1'b0;
    end else if (clockEnable) begin
      state_q <= state_d;
      bitCnt_q <= bitCnt_d;
      shiftIn_q <= shiftIn_d;
      readShift_q <= readShift_d;
      stepSel_q <= stepSel_d;
      regGain_q <= regGain_d;
      parGain_q <= parGain_d;
      gain_q <= gain_d;
      sdioOut_q <= sdioOut_d;
      sdioOe_q <= sdioOe_d;
      serial_q <= serial_d;
      power_q <= power_d;
      lowPwr_q <= lowPwr_d;
      fa_q <= fa_d;
    end
  end

  always_comb begin
    sdioOut = sdioOut_q;
    sdioOe = sdioOe_q;
    gainCode = gain_q;
    serialMode = serial_q;
    poweredUp = power_q;
    lowPowerMode = lowPwr_q;
    fastAttackActive = fa_q;
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock iff clockEnable);
  endclocking
  default disable iff (!resetn);

  sequence readCmd;
    state_q == gci_pkg::GCI_SER_WRITE && csActive && sclkRise
      && bitCnt_q == 3'h7 && shiftIn_q[6];
  endsequence

  sequence readLast;
    state_q == gci_pkg::GCI_SER_READ && csActive && sclkRise
      && bitCnt_q == 3'h7;
  endsequence

  chk_mode_select: assert property (
    serialMode == $past(!pinSync_q.mode))
    else $error("serial mode does not follow mode pin");

  chk_par_follow: assert property (
    pinSync_q.mode && !pinSync_q.latch |=> gainCode == $past(parPins))
    else $error("transparent gain did not follow pins");

  chk_par_hold: assert property (
    (pinSync_q.mode && pinSync_q.latch)[*3] |=> $stable(gainCode))
    else $error("latched gain changed");

  chk_power_pins: assert property (
    poweredUp == $past(pinSync_q.pwr) && lowPowerMode == $past(pinSync_q.perf))
    else $error("power controls do not follow pins");

  chk_sample_rise: assert property (
    state_q == gci_pkg::GCI_SER_WRITE && csActive && sclkRise
      |=> shiftIn_q[0] == $past(pinSync_q.sdio))
    else $error("serial bit not sampled on rising clock");

  chk_drive_fall: assert property (
    state_q == gci_pkg::GCI_SER_READ && csActive && sclkFall
      |=> sdioOe && sdioOut == $past(readShift_q[7]))
    else $error("read bit not driven after falling clock");

  chk_release_cs: assert property (
    serSel && !csActive |=> !sdioOe)
    else $error("data pin still driven after chip select");

  chk_read_enter: assert property (
    readCmd |=> state_q == gci_pkg::GCI_SER_READ
      && readShift_q[4:0] == $past(regGain_q))
    else $error("read flag did not start read");

  chk_read_revert: assert property (
    readLast |=> state_q == gci_pkg::GCI_SER_WRITE && !sdioOe)
    else $error("read did not revert to write");

  chk_fa_reduce: assert property (
    serSel && pinSync_q.b2 |=> fastAttackActive
      && gainCode >= $past(regGain_q)
      && (gainCode != $past(regGain_q)
      || $past(regGain_q) == `GCI_GAIN_MIN_CODE))
    else $error("fast attack did not reduce gain");

  chk_fa_restore: assert property (
    serSel && !pinSync_q.b2 |=> gainCode == $past(regGain_q))
    else $error("programmed gain not restored");

endmodule

// file: gci_gain_control_tb.sv
module gci_gain_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, resetn, sclk, csn, sdata, sdioLine, sdioOut, sdioOe;
  logic serialMode, poweredUp, lowPowerMode, fastAttackActive;
  logic [4:0] gainCode;
  gci_pkg::gci_pins_t p;
  logic [10:0] notes[$];
  int errors, n_compared;
  logic [31:0] rnd;
  event resultEv;

  assign sdioLine = sdioOe ? sdioOut : sdata;
  gci_gain_control i_dut (
    .clock(clock), .resetn(resetn), .clockEnable(1'b1),
    .modeSel(p.mode), .gain_bit4_or_sclk(p.mode ? p.b4 : sclk),
    .gain_bit3_or_csn(p.mode ? p.b3 : csn),
    .gain_bit2_or_fast_attack(p.b2), .gain_bit1(p.b1), .gain_bit0(p.b0),
    .latchSel(p.latch), .power_up_ctrl(p.pwr), .perf_mode_sel(p.perf),
    .sdioIn(sdioLine), .sdioOut(sdioOut), .sdioOe(sdioOe),
    .gainCode(gainCode), .serialMode(serialMode), .poweredUp(poweredUp),
    .lowPowerMode(lowPowerMode), .fastAttackActive(fastAttackActive)
  );
  gci_host_model i_host (
    .clock(clock), .sdioLine(sdioLine), .sclk(sclk), .csn(csn),
    .sdata(sdata)
  );
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  // reduction raises the code; saturate instead of wrapping to max gain
  function automatic logic [4:0] faGain(input logic [4:0] g, input int s);
    logic [5:0] t;
    t = {1'b0, g} + (6'h01 << s);
    return (t > 6'h1F) ? 5'h1F : t[4:0];
  endfunction
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // 8 clocks covers the 2-flop sync plus the output register
  task automatic note(input logic [4:0] g, input logic fa);
    repeat (8) @(posedge clock);
    notes.push_back({2'b00, ~p.mode, p.pwr, p.perf, fa, g});
    ->resultEv;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    #1000000;
    errors++;
    report_and_stop;
  end
  initial begin : monitor
    logic [10:0] n, seen;
    forever begin
      @(resultEv);
      #1;
      n = notes.pop_front();
      seen = n[10] ? {3'b100, i_host.lastRead} : {1'b0, sdioOe, serialMode,
        poweredUp, lowPowerMode, fastAttackActive, gainCode};
      check(seen, n);
    end
  end
  initial begin : stim
    int k;
    logic [4:0] g;
    resetn = 1'b0;
    p = 10'h28A;
    errors = 0;
    n_compared = 0;
    rnd = 32'hA175;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    note(5'h0A, 1'b0);
    for (k = 0; k < 6; k++) begin
      rnd = xs(rnd);
      {p.b4, p.b3, p.b2, p.b1, p.b0} <= rnd[4:0];
      note(rnd[4:0], 1'b0);
    end
    g = rnd[4:0];
    p.latch <= 1'b1;
    note(g, 1'b0);
    {p.b4, p.b3, p.b2, p.b1, p.b0} <= ~g;
    p.perf <= 1'b1;
    p.pwr <= 1'b0;
    note(g, 1'b0);
    p.pwr <= 1'b1;
    p.perf <= 1'b0;
    p.mode <= 1'b0;
    p.b2 <= 1'b0;
    // serial side keeps its own gain, still at the reset code
    note(5'h1F, 1'b0);
    for (k = 0; k < 4; k++) begin
      rnd = xs(rnd);
      g = (k == 3) ? 5'h1E : rnd[4:0];
      {p.b1, p.b0} <= rnd[6:5];
      i_host.frame({1'b0, k[1:0], g}, 8);
      note(g, 1'b0);
      p.b2 <= 1'b1;
      note(faGain(g, k), 1'b1);
      p.b2 <= 1'b0;
      note(g, 1'b0);
    end
    i_host.frame(8'h80, 16);
    notes.push_back({3'b100, 8'h7E});
    ->resultEv;
    note(5'h1E, 1'b0);
    i_host.frame(8'h05, 8);
    note(5'h05, 1'b0);
    i_host.frame(8'h1F, 5);
    note(5'h05, 1'b0);
    report_and_stop;
  end
endmodule

// file: gci_host_model.sv
module gci_host_model (
  input wire logic clock, // system clock, paces the link
  input wire logic sdioLine, // resolved data pin level
  output logic sclk, // serial clock, idle low
  output logic csn, // chip select, active low
  output logic sdata // host data level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] lastRead;
  initial begin
    sclk = 1'b0;
    csn = 1'b1;
    sdata = 1'b0;
    lastRead = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////
  // half period of 4 clocks gives the 800 ns link clock
  // past bit 7 the host keeps driving, but its level toggles every bit
  task automatic frame(input logic [7:0] w, input int n);
    int i;
    csn <= 1'b0;
    repeat (4) @(posedge clock);
    for (i = 0; i < n; i++) begin
      sdata <= (i < 8) ? w[7-i] : ~sdata;
      repeat (4) @(posedge clock);
      sclk <= 1'b1;
      @(posedge clock);
      if (i >= 8) lastRead <= {lastRead[6:0], sdioLine};
      repeat (3) @(posedge clock);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clock);
    csn <= 1'b1;
    sdata <= ~sdata;
    repeat (4) @(posedge clock);
  endtask
endmodule

// file: gci_pkg.sv
package gci_pkg;
  typedef struct packed {
    logic mode;
    logic latch;
    logic pwr;
    logic perf;
    logic sdio;
    logic b4;
    logic b3;
    logic b2;
    logic b1;
    logic b0;
  } gci_pins_t;

  typedef enum logic [1:0] {
    GCI_SER_WRITE = 2'b01,
    GCI_SER_READ = 2'b10
  } gci_state_t;
endpackage
